// [channel_output_config_regs_tb.sv]
// self-checking bench for the channel config bank
// assumes the bound checker and the host model beside it
`timescale 1ns/10ps

module channel_output_config_regs_tb;
  logic clk, rst_n, cwa, bw, clr, pin, trig, ok;
  logic [11:0] cd, bd;
  logic [15:0] ua, la, rdv;
  logic wr, rd, aerr, rv, pa, bad_a, hyb, wib, bdb, bsa;
  logic cwb, pb, bsb, hya, wia;
  logic [11:0] code_b, hib, lob;
  logic [1:0] dir_b, scl_b;
  logic [7:0] addr;
  logic [15:0] wd, rdat;
  logic [11:0] code_a, hia, loa;
  logic [1:0] dir_a, scl_a;
  logic [12:0] wave_a, wave_b;
  int err_count, cmp_count, i;
  logic [40:0] rows [0:6] = '{{1'b0, 8'h04, 16'hffff, 16'h1e00},
    {1'b0, 8'h05, 16'hffff, 16'h0c00}, {1'b0, 8'h06, 16'hffff, 16'hffff},
    {1'b0, 8'h16, 16'ha5a5, 16'h0400}, {1'b0, 8'h17, 16'h5a5a, 16'h0800},
    {1'b0, 8'h18, 16'h5a5a, 16'h5a5a}, {1'b1, 8'h07, 16'hffff, 16'h0000}};

  chcfg_host i_chcfg_host (.i_clk(clk), .i_reg_rdata(rdat), .i_reg_rd_valid(rv),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wd));

  chcfg_top i_chcfg_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rd_valid(rv),
    .o_reg_addr_err(aerr), .i_code_wr_a(cwa), .i_code_wr_b(cwb), .i_code_data(cd),
    .i_bcast_wr(bw), .i_bcast_data(bd), .i_clear(clr), .i_load_strobe_pin(pin),
    .i_trig_load(trig), .i_upper_bound_a(ua), .i_lower_bound_a(la),
    .i_upper_bound_b(la), .i_lower_bound_b(ua), .o_code_a(code_a),
    .o_pending_a(pa), .o_span_dir_a(dir_a), .o_span_scale_a(scl_a),
    .o_current_span_sel_bad_a(bsa), .o_hyst_en_a(hya), .o_window_en_a(wia),
    .o_threshold_mode_sel_bad_a(bad_a), .o_hi_thr_a(hia), .o_lo_thr_a(loa),
    .o_waveform_cfg_field_a(wave_a), .o_code_b(code_b), .o_pending_b(pb),
    .o_span_dir_b(dir_b), .o_span_scale_b(scl_b), .o_current_span_sel_bad_b(bsb),
    .o_hyst_en_b(hyb), .o_window_en_b(wib), .o_threshold_mode_sel_bad_b(bdb),
    .o_hi_thr_b(hib), .o_lo_thr_b(lob), .o_waveform_cfg_field_b(wave_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(3);
  endtask

  task automatic code_wr(input logic b, input logic [11:0] d);
    tick(1);
    cwa = ~b;
    bw = b;
    cd = d;
    bd = d;
    tick(1);
    cwa = 1'b0;
    bw = 1'b0;
    tick(2);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    {cwa, cwb, bw, clr, trig} = 5'h00;
    pin = 1'b1;
    cd = 12'h000;
    bd = 12'h000;
    ua = 16'h0000;
    la = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    do_reset();
    for (i = 0; i < 7; i++) begin
      i_chcfg_host.wr(rows[i][39:32], rows[i][31:16]);
      i_chcfg_host.rd(rows[i][39:32], rdv, ok);
      chk(rdv, rows[i][15:0]);
      chk({ok, aerr}, {1'b1, rows[i][40]});
    end
    chk({3'h0, wave_b}, 16'h1a5a);
    chk({3'h0, wave_a}, 16'h1fff);
    chk({bsb, dir_b, scl_b}, 5'h02);
    $display("test readback done");
    for (i = 0; i < 16; i++) begin
      i_chcfg_host.wr(8'h04, {3'h0, i[3:0], 9'h000});
      tick(2);
      chk({bsa, dir_a, scl_a}, i < 12 ? {1'b0, i[3:2], i[1:0]} : 5'h1c);
    end
    $display("test span done");
    for (i = 0; i < 4; i++) begin
      i_chcfg_host.wr(8'h17, {4'h0, i[1:0], 10'h000});
      i_chcfg_host.wr(8'h05, {4'h0, i[1:0], 10'h000});
      tick(2);
      chk({bad_a, hya, wia}, {i == 3, i == 1, i == 2});
      chk({bdb, hyb, wib}, {i == 3, i == 1, i == 2});
    end
    ua = 16'habcf;
    la = 16'h1234;
    tick(3);
    chk({hia, loa[11:8]}, 16'habc1);
    chk({hib, lob[3:0]}, 16'h123c);
    $display("test mode done");
    i_chcfg_host.wr(8'h06, 16'h0000);
    code_wr(1'b0, 12'h123);
    chk(code_a, 12'h123);
    code_wr(1'b1, 12'h456);
    chk(code_a, 12'h123);
    i_chcfg_host.wr(8'h06, 16'h2000);
    code_wr(1'b1, 12'h456);
    chk(code_a, 12'h456);
    chk(code_b, 12'h000);
    i_chcfg_host.wr(8'h06, 16'h6000);
    code_wr(1'b0, 12'h789);
    chk({pa, code_a}, 13'h1456);
    pin = 1'b0;
    tick(1);
    pin = 1'b1;
    tick(2);
    chk({pa, code_a}, 13'h0789);
    code_wr(1'b0, 12'h0aa);
    cwb = 1'b1;
    cd = 12'h0bb;
    tick(1);
    cwb = 1'b0;
    tick(2);
    chk({pb, code_b}, 13'h1000);
    trig = 1'b1;
    tick(1);
    trig = 1'b0;
    tick(2);
    chk({pa, code_a}, 13'h00aa);
    chk({pb, code_b}, 13'h00bb);
    for (i = 0; i < 2; i++) begin
      i_chcfg_host.wr(8'h06, {i[0], 15'h6000});
      code_wr(1'b0, 12'h3c3);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(2);
      chk({pa, code_a}, {1'b0, i[0], 11'h000});
      chk({pb, code_b}, 13'h0000);
    end
    $display("test code path done");
    do_reset();
    for (i = 0; i < 6; i++) begin
      i_chcfg_host.rd(rows[i][39:32], rdv, ok);
      chk(rdv, 16'h0000);
    end
    chk({3'h0, wave_a}, 16'h0000);
    $display("test reset done");
    give_verdict();
  end
endmodule

// [chcfg_chan.v]
// one channel's three configuration registers
// assumes a one-cycle write pulse with address and data valid together
`timescale 1ns/10ps
`include "chcfg_regs.vh"

module chcfg_chan #(
  parameter [7:0] ADDR_SPAN = `CHCFG_ADDR_SPAN_A,
  parameter [7:0] ADDR_MODE = `CHCFG_ADDR_MODE_A,
  parameter [7:0] ADDR_FUNC = `CHCFG_ADDR_FUNC_A
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // register write
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  // stored fields
  output reg [3:0] o_span_r,
  output reg [1:0] o_mode_r,
  output reg [15:0] o_func_r
);

  ////////////////////////////////////////////////////////////////////////////
  // whole-word capture, don't-care bits never stored
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_span_r <= `CHCFG_SPAN_RST;
      o_mode_r <= `CHCFG_MODE_RST;
      o_func_r <= `CHCFG_RST_VAL;
    end else if (i_wr_en) begin
      if (i_addr == ADDR_SPAN) begin
        o_span_r <= i_wdata[`CHCFG_SPAN_MSB:`CHCFG_SPAN_LSB]; // R4 R16 R17
      end
      if (i_addr == ADDR_MODE) begin
        o_mode_r <= i_wdata[`CHCFG_MODE_MSB:`CHCFG_MODE_LSB]; // R8 R16
      end
      if (i_addr == ADDR_FUNC) begin
        o_func_r <= i_wdata; // R13 R17
      end
    end
  end

endmodule

// [chcfg_code.v]
// one channel's output code path: immediate or deferred update, clear
// assumes write, broadcast, clear and load arrive as one-cycle pulses
`timescale 1ns/10ps

module chcfg_code #(
  parameter CODE_W = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // code writes
  input wire i_wr,
  input wire i_bcast,
  input wire [CODE_W-1:0] i_data,
  input wire [CODE_W-1:0] i_bdata,
  // configuration
  input wire i_defer,
  input wire i_join,
  input wire i_clr_sel,
  // events
  input wire i_clear,
  input wire i_load,
  // state
  output reg [CODE_W-1:0] o_code_r,
  output reg [CODE_W-1:0] o_stage_r,
  output reg o_pending_r
);

  localparam [CODE_W-1:0] MID = {1'b1, {(CODE_W-1){1'b0}}};

  wire take_b = i_bcast & i_join; // R12
  wire take = i_wr | take_b;
  wire [CODE_W-1:0] new_code = i_wr ? i_data : i_bdata;
  wire [CODE_W-1:0] clr_code = i_clr_sel ? MID : {CODE_W{1'b0}}; // R9

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code_r <= {CODE_W{1'b0}};
      o_stage_r <= {CODE_W{1'b0}};
      o_pending_r <= 1'b0;
    end else if (i_clear) begin
      o_code_r <= clr_code; // R9
      o_stage_r <= clr_code;
      o_pending_r <= 1'b0;
    end else if (take) begin
      o_stage_r <= new_code;
      if (!i_defer) begin
        o_code_r <= new_code; // R10
        o_pending_r <= 1'b0;
      end else begin
        o_pending_r <= 1'b1;
        if (i_load && o_pending_r) begin
          o_code_r <= o_stage_r; // R11
        end
      end
    end else if (i_load && o_pending_r) begin
      o_code_r <= o_stage_r; // R11
      o_pending_r <= 1'b0;
    end
  end

endmodule

// [chcfg_host.sv]
// host model: drives register write and read pulses into the bank
// assumes read answers come registered one cycle after the read pulse
`timescale 1ns/10ps

module chcfg_host (
  // clock
  input wire i_clk,
  // answers
  input wire [15:0] i_reg_rdata,
  input wire i_reg_rd_valid,
  // requests
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 16'h0000;
  end

  // comparator is never enabled, so current output need not be powered down
  // idle lines flip so a stale value cannot pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge i_clk);
    #1;
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    ok = i_reg_rd_valid;
    d = i_reg_rdata;
  endtask
endmodule

// [chcfg_regs.vh]
// register offsets, field layouts, reset values and codes of the channel config bank
// assumes registers are reached at their printed byte offsets over the serial port
`ifndef CHCFG_REGS_VH
`define CHCFG_REGS_VH

`define CHCFG_ADDR_SPAN_A 8'h04
`define CHCFG_ADDR_MODE_A 8'h05
`define CHCFG_ADDR_FUNC_A 8'h06
`define CHCFG_ADDR_SPAN_B 8'h16
`define CHCFG_ADDR_MODE_B 8'h17
`define CHCFG_ADDR_FUNC_B 8'h18

`define CHCFG_RST_VAL 16'h0000

`define CHCFG_SPAN_MSB 12
`define CHCFG_SPAN_LSB 9
`define CHCFG_MODE_MSB 11
`define CHCFG_MODE_LSB 10
`define CHCFG_CLR_BIT 15
`define CHCFG_DEFER_BIT 14
`define CHCFG_JOIN_BIT 13
`define CHCFG_WAVE_MSB 12
`define CHCFG_WAVE_LSB 0
`define CHCFG_BOUND_MSB 15
`define CHCFG_BOUND_LSB 4

`define CHCFG_SPAN_RST 4'h0
`define CHCFG_MODE_RST 2'h0

`define CHCFG_MODE_PLAIN 2'h0
`define CHCFG_MODE_HYST 2'h1
`define CHCFG_MODE_WINDOW 2'h2

`define CHCFG_DIR_SOURCE 2'h0
`define CHCFG_DIR_SINK 2'h1
`define CHCFG_DIR_BIPOLAR 2'h2
`define CHCFG_DIR_INVALID 2'h3

`define CHCFG_SCALE_25 2'h0
`define CHCFG_SCALE_50 2'h1
`define CHCFG_SCALE_125 2'h2
`define CHCFG_SCALE_250 2'h3

`endif

// [chcfg_top.v]
// channel output configuration register bank for two channels
// assumes host-side decoder delivers register and code accesses as
// one-cycle pulses synchronous to i_core_clk
//
// Behaviour
// R1: span codes 0-3 source 25/50/125/250uA
// R2: span codes 4-7 sink 24/48/120/240uA
// R3: codes 8-11 bipolar; others invalid
// R4: span field bits 12:9, resets zero
// R5: threshold mode 00: plain comparator
// R6: mode 01: hysteresis from bound codes
// R7: mode 10: window from bound codes
// R8: separate threshold mode register per channel
// R9: clear level bit: zero or mid-scale
// R10: deferred bit 0: update right after write
// R11: deferred bit 1: update on load event
// R12: join bit gates broadcast writes
// R13: function register resets to zero
// R14: bound codes taken from bits 15:4
// R15: host powers current output down first; the host model writes the span register without any power-down
// R16: don't-care bits ignored, read zero
// R17: register write updates fields together
`timescale 1ns/10ps
`include "chcfg_regs.vh"

module chcfg_top #(
  parameter CODE_W = 12
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // register access
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rd_valid,
  output reg o_reg_addr_err,
  // code writes
  input wire i_code_wr_a,
  input wire i_code_wr_b,
  input wire [CODE_W-1:0] i_code_data,
  input wire i_bcast_wr,
  input wire [CODE_W-1:0] i_bcast_data,
  // clear and load
  input wire i_clear,
  input wire i_load_strobe_pin,
  input wire i_trig_load,
  // bound codes
  input wire [15:0] i_upper_bound_a,
  input wire [15:0] i_lower_bound_a,
  input wire [15:0] i_upper_bound_b,
  input wire [15:0] i_lower_bound_b,
  // channel a
  output reg [CODE_W-1:0] o_code_a,
  output reg o_pending_a,
  output reg [1:0] o_span_dir_a,
  output reg [1:0] o_span_scale_a,
  output reg o_current_span_sel_bad_a,
  output reg o_hyst_en_a,
  output reg o_window_en_a,
  output reg o_threshold_mode_sel_bad_a,
  output reg [11:0] o_hi_thr_a,
  output reg [11:0] o_lo_thr_a,
  output reg [12:0] o_waveform_cfg_field_a,
  // channel b
  output reg [CODE_W-1:0] o_code_b,
  output reg o_pending_b,
  output reg [1:0] o_span_dir_b,
  output reg [1:0] o_span_scale_b,
  output reg o_current_span_sel_bad_b,
  output reg o_hyst_en_b,
  output reg o_window_en_b,
  output reg o_threshold_mode_sel_bad_b,
  output reg [11:0] o_hi_thr_b,
  output reg [11:0] o_lo_thr_b,
  output reg [12:0] o_waveform_cfg_field_b
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n = rst_s2_r;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  wire [3:0] span_a;
  wire [1:0] mode_a;
  wire [15:0] func_a;
  wire [3:0] span_b;
  wire [1:0] mode_b;
  wire [15:0] func_b;

  chcfg_chan #(
    .ADDR_SPAN(`CHCFG_ADDR_SPAN_A),
    .ADDR_MODE(`CHCFG_ADDR_MODE_A),
    .ADDR_FUNC(`CHCFG_ADDR_FUNC_A)
  ) u_chan_a (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_wr_en(i_reg_wr),
    .i_addr(i_reg_addr),
    .i_wdata(i_reg_wdata),
    .o_span_r(span_a),
    .o_mode_r(mode_a),
    .o_func_r(func_a)
  );

  chcfg_chan #(
    .ADDR_SPAN(`CHCFG_ADDR_SPAN_B),
    .ADDR_MODE(`CHCFG_ADDR_MODE_B),
    .ADDR_FUNC(`CHCFG_ADDR_FUNC_B)
  ) u_chan_b (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_wr_en(i_reg_wr),
    .i_addr(i_reg_addr),
    .i_wdata(i_reg_wdata),
    .o_span_r(span_b),
    .o_mode_r(mode_b),
    .o_func_r(func_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read-back, don't-care bits as zero
  reg [15:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 16'h0000;
    rd_hit = 1'b1;
    case (i_reg_addr)
      `CHCFG_ADDR_SPAN_A: rd_mux[`CHCFG_SPAN_MSB:`CHCFG_SPAN_LSB] = span_a; // R16
      `CHCFG_ADDR_MODE_A: rd_mux[`CHCFG_MODE_MSB:`CHCFG_MODE_LSB] = mode_a; // R16
      `CHCFG_ADDR_FUNC_A: rd_mux = func_a;
      `CHCFG_ADDR_SPAN_B: rd_mux[`CHCFG_SPAN_MSB:`CHCFG_SPAN_LSB] = span_b; // R16
      `CHCFG_ADDR_MODE_B: rd_mux[`CHCFG_MODE_MSB:`CHCFG_MODE_LSB] = mode_b; // R16
      `CHCFG_ADDR_FUNC_B: rd_mux = func_b;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rd_valid <= 1'b0;
      o_reg_addr_err <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd;
      o_reg_addr_err <= (i_reg_rd | i_reg_wr) & ~rd_hit;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load event: strobe pin falling edge or trigger bit
  reg load_pin_q_r;
  wire load_evt = (load_pin_q_r & ~i_load_strobe_pin) | i_trig_load; // R11

  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pin_q_r <= 1'b1;
    end else begin
      load_pin_q_r <= i_load_strobe_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output code paths
  wire [CODE_W-1:0] code_a;
  wire [CODE_W-1:0] code_b;
  wire pend_a;
  wire pend_b;

  chcfg_code #(
    .CODE_W(CODE_W)
  ) u_code_a (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_wr(i_code_wr_a),
    .i_bcast(i_bcast_wr),
    .i_data(i_code_data),
    .i_bdata(i_bcast_data),
    .i_defer(func_a[`CHCFG_DEFER_BIT]),
    .i_join(func_a[`CHCFG_JOIN_BIT]),
    .i_clr_sel(func_a[`CHCFG_CLR_BIT]),
    .i_clear(i_clear),
    .i_load(load_evt),
    .o_code_r(code_a),
    .o_stage_r(),
    .o_pending_r(pend_a)
  );

  chcfg_code #(
    .CODE_W(CODE_W)
  ) u_code_b (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_wr(i_code_wr_b),
    .i_bcast(i_bcast_wr),
    .i_data(i_code_data),
    .i_bdata(i_bcast_data),
    .i_defer(func_b[`CHCFG_DEFER_BIT]),
    .i_join(func_b[`CHCFG_JOIN_BIT]),
    .i_clr_sel(func_b[`CHCFG_CLR_BIT]),
    .i_clear(i_clear),
    .i_load(load_evt),
    .o_code_r(code_b),
    .o_stage_r(),
    .o_pending_r(pend_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  // span code -> {bad, direction, scale}
  function [4:0] span_dec;
    input [3:0] s;
    begin
      case (s[3:2])
        2'h0: span_dec = {1'b0, `CHCFG_DIR_SOURCE, s[1:0]}; // R1
        2'h1: span_dec = {1'b0, `CHCFG_DIR_SINK, s[1:0]}; // R2
        2'h2: span_dec = {1'b0, `CHCFG_DIR_BIPOLAR, s[1:0]}; // R3
        default: span_dec = {1'b1, `CHCFG_DIR_INVALID, `CHCFG_SCALE_25}; // R3
      endcase
    end
  endfunction

  // mode code -> {bad, window, hysteresis}
  function [2:0] mode_dec;
    input [1:0] m;
    begin
      case (m)
        `CHCFG_MODE_PLAIN: mode_dec = 3'b000; // R5
        `CHCFG_MODE_HYST: mode_dec = 3'b001; // R6
        `CHCFG_MODE_WINDOW: mode_dec = 3'b010; // R7
        default: mode_dec = 3'b100; // R7
      endcase
    end
  endfunction

  wire [4:0] sd_a = span_dec(span_a);
  wire [4:0] sd_b = span_dec(span_b);
  wire [2:0] md_a = mode_dec(mode_a);
  wire [2:0] md_b = mode_dec(mode_b);

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_code_a <= {CODE_W{1'b0}};
      o_pending_a <= 1'b0;
      o_span_dir_a <= `CHCFG_DIR_SOURCE;
      o_span_scale_a <= `CHCFG_SCALE_25;
      o_current_span_sel_bad_a <= 1'b0;
      o_hyst_en_a <= 1'b0;
      o_window_en_a <= 1'b0;
      o_threshold_mode_sel_bad_a <= 1'b0;
      o_hi_thr_a <= 12'h000;
      o_lo_thr_a <= 12'h000;
      o_waveform_cfg_field_a <= 13'h0000;
      o_code_b <= {CODE_W{1'b0}};
      o_pending_b <= 1'b0;
      o_span_dir_b <= `CHCFG_DIR_SOURCE;
      o_span_scale_b <= `CHCFG_SCALE_25;
      o_current_span_sel_bad_b <= 1'b0;
      o_hyst_en_b <= 1'b0;
      o_window_en_b <= 1'b0;
      o_threshold_mode_sel_bad_b <= 1'b0;
      o_hi_thr_b <= 12'h000;
      o_lo_thr_b <= 12'h000;
      o_waveform_cfg_field_b <= 13'h0000;
    end else begin
      o_code_a <= code_a;
      o_pending_a <= pend_a;
      {o_current_span_sel_bad_a, o_span_dir_a, o_span_scale_a} <= sd_a; // R1 R2 R3
      {o_threshold_mode_sel_bad_a, o_window_en_a, o_hyst_en_a} <= md_a; // R5 R6 R7
      o_hi_thr_a <= i_upper_bound_a[`CHCFG_BOUND_MSB:`CHCFG_BOUND_LSB]; // R14
      o_lo_thr_a <= i_lower_bound_a[`CHCFG_BOUND_MSB:`CHCFG_BOUND_LSB]; // R14
      o_waveform_cfg_field_a <= func_a[`CHCFG_WAVE_MSB:`CHCFG_WAVE_LSB];
      o_code_b <= code_b;
      o_pending_b <= pend_b;
      {o_current_span_sel_bad_b, o_span_dir_b, o_span_scale_b} <= sd_b; // R1 R2 R3
      {o_threshold_mode_sel_bad_b, o_window_en_b, o_hyst_en_b} <= md_b; // R5 R6 R7
      o_hi_thr_b <= i_upper_bound_b[`CHCFG_BOUND_MSB:`CHCFG_BOUND_LSB]; // R14
      o_lo_thr_b <= i_lower_bound_b[`CHCFG_BOUND_MSB:`CHCFG_BOUND_LSB]; // R14
      o_waveform_cfg_field_b <= func_b[`CHCFG_WAVE_MSB:`CHCFG_WAVE_LSB];
    end
  end

endmodule

// [chcfg_top_sva.sv]
// checker for the channel config bank, watching top-level ports only
// assumes one clock domain and accesses made by the host model
`timescale 1ns/10ps

module chcfg_top_sva #(
  parameter CODE_W = 12
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_code_wr_a,
  input wire i_bcast_wr,
  input wire i_clear,
  input wire i_load_strobe_pin,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_rd_valid,
  input wire o_reg_addr_err,
  input wire [CODE_W-1:0] o_code_a,
  input wire o_pending_a,
  input wire [1:0] o_span_dir_a,
  input wire [1:0] o_span_scale_a,
  input wire o_hyst_en_a,
  input wire o_window_en_a,
  input wire o_threshold_mode_sel_bad_b
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  wire acc = i_reg_wr | i_reg_rd;
  wire mapped = (i_reg_addr == 8'h04) | (i_reg_addr == 8'h05) | (i_reg_addr == 8'h06) |
                (i_reg_addr == 8'h16) | (i_reg_addr == 8'h17) | (i_reg_addr == 8'h18);
  wire wr_span_a = i_reg_wr & (i_reg_addr == 8'h04);
  wire wr_mode_a = i_reg_wr & (i_reg_addr == 8'h05);
  wire wr_mode_b = i_reg_wr & (i_reg_addr == 8'h17);

  a_read_answer: assert property (i_reg_rd |=> o_reg_rd_valid)
    else $error("read not answered");
  a_unmapped_err: assert property (acc && !mapped |=> o_reg_addr_err)
    else $error("unmapped access not flagged");
  a_mapped_no_err: assert property (acc && mapped |=> !o_reg_addr_err)
    else $error("mapped access flagged");
  a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_span_source: assert property (wr_span_a && i_reg_wdata[12:11] == 2'b00 ##1 !wr_span_a
      |=> o_span_dir_a == 2'h0 && o_span_scale_a == $past(i_reg_wdata[10:9], 2))
    else $error("source span decoded wrongly");
  a_mode_hyst: assert property (wr_mode_a && i_reg_wdata[11:10] == 2'b01 ##1 !wr_mode_a
      |=> o_hyst_en_a && !o_window_en_a)
    else $error("hysteresis mode not decoded");
  a_mode_bad: assert property (wr_mode_b && i_reg_wdata[11:10] == 2'b11 ##1 !wr_mode_b
      |=> o_threshold_mode_sel_bad_b)
    else $error("invalid mode not flagged");
  a_clear_level: assert property (i_clear |-> ##[1:2]
      (o_code_a == 0 || o_code_a == (1 << (CODE_W - 1))) && !o_pending_a)
    else $error("clear gave a wrong code");
  a_pin_loads: assert property (o_pending_a && $fell(i_load_strobe_pin) && !i_code_wr_a &&
      !i_bcast_wr |-> ##[1:2] !o_pending_a)
    else $error("load strobe did not load");

  c_unmapped: cover property (acc && !mapped);
  c_pending: cover property (o_pending_a ##1 !o_pending_a);
  c_clear: cover property (i_clear);
endmodule

bind chcfg_top chcfg_top_sva #(.CODE_W(CODE_W)) i_chcfg_top_sva (.i_core_clk, .i_rst_n,
  .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_code_wr_a, .i_bcast_wr, .i_clear,
  .i_load_strobe_pin, .o_reg_rdata, .o_reg_rd_valid, .o_reg_addr_err, .o_code_a,
  .o_pending_a, .o_span_dir_a, .o_span_scale_a, .o_hyst_en_a, .o_window_en_a,
  .o_threshold_mode_sel_bad_b);
